// ---- rtl/vector_map_pkg.sv ----
// Package of vector addresses, control register layout and timing counts
package vector_map_pkg;

	localparam int ADDR_W = 16;
	localparam int NUM_REQ = 24;

	// Reset and vector table
	localparam logic [15:0] RESET_ADDR_APP = 16'h0000;
	localparam logic [15:0] TABLE_START = 16'h0002;
	localparam logic [15:0] VECTOR_STRIDE = 16'h0002;
	localparam logic [15:0] RESERVED_SLOT = 16'h002C;
	localparam int RESERVED_INDEX = 21;
	localparam int GROUP_TWO_INDEX = 22;
	localparam int GROUP_THREE_INDEX = 23;

	// Boot section start, word address
	localparam logic [15:0] BOOT_START_DEFAULT = 16'h3800;

	// Fuse decode
	localparam logic FUSE_UNPROGRAMMED = 1'b1;
	localparam logic FUSE_PROGRAMMED = 1'b0;

	// Core control register map
	localparam logic [7:0] REG_CORE_CONTROL = 8'h00;
	localparam logic [7:0] REG_IRQ_STATUS = 8'h01;
	localparam logic [7:0] REG_IRQ_MASK = 8'h02;
	localparam logic [7:0] REG_PENDING_VECTOR = 8'h03;
	localparam int BIT_VECTOR_CHANGE_ENABLE = 0;
	localparam int BIT_VECTOR_TABLE_SELECT = 1;
	localparam logic [7:0] CORE_CONTROL_RESET = 8'h00;

	// Status events
	localparam int EVT_WINDOW_EXPIRED = 0;
	localparam int EVT_TABLE_MOVED = 1;
	localparam int EVT_REJECTED_WRITE = 2;
	localparam int NUM_EVT = 3;

	// Change window
	localparam int CHANGE_WINDOW_CYCLES = 4;
	localparam logic [2:0] CHANGE_WINDOW_COUNT = 3'(CHANGE_WINDOW_CYCLES);

endpackage

// ---- rtl/vector_req_if.sv ----
// Interface carrying pending requests and the chosen vector between modules
`timescale 1ns/1ns
`default_nettype none
interface vector_req_if #(parameter int NUM = 24);
	logic [NUM-1:0] pending;
	logic found;
	logic [4:0] index;

	modport encoder (input pending, output found, output index);
	modport top (output pending, input found, input index);
endinterface
`default_nettype wire

// ---- rtl/vector_priority_encoder.sv ----
// Lowest-index priority encoder over the pending request lines
`timescale 1ns/1ns
`default_nettype none
module vector_priority_encoder #(
	parameter int NUM = 24
) (
	vector_req_if.encoder req
);
	always_comb begin
		req.found = 1'b0;
		req.index = 5'h00;
		for (int i = NUM - 1; i >= 0; i--) begin
			if (req.pending[i]) begin
				req.found = 1'b1;
				req.index = 5'(i);
			end
		end
	end
endmodule
`default_nettype wire

// ---- rtl/reset_interrupt_vector_map.sv ----
// Reset and interrupt vector address generator with movable vector table
`timescale 1ns/1ns
`default_nettype none
module reset_interrupt_vector_map #(
	parameter int NUM_REQ = vector_map_pkg::NUM_REQ,
	parameter bit LARGE_VARIANT = 1'b1,
	parameter logic [15:0] BOOT_START = vector_map_pkg::BOOT_START_DEFAULT
) (
	// Clock, reset, enable
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	// Fuse
	input wire logic boot_reset_select_fuse_in,
	// Register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [7:0] reg_rdata_out,
	// Core side
	input wire logic [NUM_REQ-1:0] request_in,
	input wire logic global_enable_in,
	input wire logic instr_done_in,
	input wire logic irq_ack_in,
	output logic irq_request_out,
	output logic [15:0] irq_vector_out,
	output logic [15:0] reset_vector_out,
	output logic irq_blocked_out,
	// Interrupt
	output logic irq_out
);
	typedef enum logic [1:0] {IDLE, WINDOW, AFTER_WRITE} phase_t;

	typedef struct packed {
		phase_t phase;
		logic [2:0] count;
		logic change_enable;
		logic table_select;
		logic [vector_map_pkg::NUM_EVT-1:0] status;
		logic [vector_map_pkg::NUM_EVT-1:0] mask;
		logic [7:0] rdata;
		logic [15:0] vector;
		logic [15:0] reset_vector;
		logic request;
	} state_t;

	state_t s;
	state_t next_s;

	// ------------------------------------------------------------
	// Request qualification and priority
	// ------------------------------------------------------------
	vector_req_if #(.NUM(NUM_REQ)) req_bus ();
	logic [NUM_REQ-1:0] qualified;

	genvar g;
	generate
		for (g = 0; g < NUM_REQ; g++) begin : gen_qual
			if (g == vector_map_pkg::RESERVED_INDEX) begin : gen_res
				assign qualified[g] = 1'b0;
			end else if ((g == vector_map_pkg::GROUP_TWO_INDEX
				|| g == vector_map_pkg::GROUP_THREE_INDEX) && !LARGE_VARIANT) begin : gen_abs
				assign qualified[g] = 1'b0;
			end else begin : gen_live
				assign qualified[g] = request_in[g];
			end
		end
	endgenerate

	assign req_bus.pending = qualified;

	vector_priority_encoder #(.NUM(NUM_REQ)) u_encoder (
		.req(req_bus.encoder)
	);

	logic blocked;
	logic [15:0] boot_base;
	logic [15:0] table_base;
	logic [15:0] vector_addr;
	logic wr_ctrl;
	logic opening;

	assign blocked = (s.phase != IDLE);
	assign boot_base = s.table_select ? BOOT_START : 16'h0000;
	assign table_base = boot_base + vector_map_pkg::TABLE_START;
	assign vector_addr = table_base + 16'(req_bus.index * vector_map_pkg::VECTOR_STRIDE);
	assign wr_ctrl = reg_write_in && reg_addr_in == vector_map_pkg::REG_CORE_CONTROL;
	// Blocking starts in the very cycle the change enable is written
	assign opening = wr_ctrl && reg_wdata_in[vector_map_pkg::BIT_VECTOR_CHANGE_ENABLE];

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic [vector_map_pkg::NUM_EVT-1:0] evt;
		evt = '0;
		next_s = s;
		next_s.rdata = 8'h00;
		next_s.reset_vector = (boot_reset_select_fuse_in == vector_map_pkg::FUSE_PROGRAMMED)
			? BOOT_START : vector_map_pkg::RESET_ADDR_APP;
		case (s.phase)
			IDLE: begin
				next_s.phase = IDLE;
			end
			WINDOW: begin
				if (s.count == 3'h1) begin
					next_s.phase = IDLE;
					next_s.change_enable = 1'b0;
					evt[vector_map_pkg::EVT_WINDOW_EXPIRED] = 1'b1;
				end
				next_s.count = s.count - 3'h1;
			end
			AFTER_WRITE: begin
				if (instr_done_in) begin
					next_s.phase = IDLE;
				end
			end
			default: begin
				next_s.phase = IDLE;
			end
		endcase
		if (wr_ctrl) begin
			if (reg_wdata_in[vector_map_pkg::BIT_VECTOR_CHANGE_ENABLE]) begin
				if (s.phase == WINDOW) begin
					evt[vector_map_pkg::EVT_REJECTED_WRITE] = 1'b1;
				end
				next_s.phase = WINDOW;
				next_s.change_enable = 1'b1;
				next_s.count = vector_map_pkg::CHANGE_WINDOW_COUNT;
			end else if (s.phase == WINDOW) begin
				next_s.table_select = reg_wdata_in[vector_map_pkg::BIT_VECTOR_TABLE_SELECT];
				next_s.change_enable = 1'b0;
				next_s.phase = AFTER_WRITE;
				evt[vector_map_pkg::EVT_TABLE_MOVED] = 1'b1;
			end else begin
				evt[vector_map_pkg::EVT_REJECTED_WRITE] = 1'b1;
			end
		end
		// Accepted interrupt: latch address while core may fetch it
		if (!blocked && !opening && global_enable_in && req_bus.found && !s.request) begin
			next_s.request = 1'b1;
			next_s.vector = vector_addr;
		end else if (irq_ack_in || blocked || opening) begin
			next_s.request = 1'b0;
		end
		// Status: write-one clear, set wins
		if (reg_write_in && reg_addr_in == vector_map_pkg::REG_IRQ_STATUS) begin
			next_s.status = s.status & ~reg_wdata_in[vector_map_pkg::NUM_EVT-1:0];
		end
		next_s.status = next_s.status | evt;
		if (reg_write_in && reg_addr_in == vector_map_pkg::REG_IRQ_MASK) begin
			next_s.mask = reg_wdata_in[vector_map_pkg::NUM_EVT-1:0];
		end
		if (reg_read_in) begin
			case (reg_addr_in)
				vector_map_pkg::REG_CORE_CONTROL: begin
					next_s.rdata = {6'h00, s.table_select, s.change_enable};
				end
				vector_map_pkg::REG_IRQ_STATUS: begin
					next_s.rdata = {5'h00, s.status};
				end
				vector_map_pkg::REG_IRQ_MASK: begin
					next_s.rdata = {5'h00, s.mask};
				end
				vector_map_pkg::REG_PENDING_VECTOR: begin
					next_s.rdata = {2'h0, req_bus.found, req_bus.index};
				end
				default: begin
					next_s.rdata = 8'h00;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s <= '0;
			s.phase <= IDLE;
			s.change_enable <= vector_map_pkg::CORE_CONTROL_RESET[vector_map_pkg::BIT_VECTOR_CHANGE_ENABLE];
			s.table_select <= vector_map_pkg::CORE_CONTROL_RESET[vector_map_pkg::BIT_VECTOR_TABLE_SELECT];
			s.reset_vector <= vector_map_pkg::RESET_ADDR_APP;
		end else if (clk_en_in) begin
			s <= next_s;
		end
	end

	assign reg_rdata_out = s.rdata;
	assign irq_request_out = s.request;
	assign irq_vector_out = s.vector;
	assign reset_vector_out = s.reset_vector;
	assign irq_blocked_out = blocked;
	assign irq_out = |(s.status & s.mask);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence enable_written;
		clk_en_in && wr_ctrl && reg_wdata_in[vector_map_pkg::BIT_VECTOR_CHANGE_ENABLE];
	endsequence
	sequence idle_cycles;
		(clk_en_in && !wr_ctrl) [*4];
	endsequence

	chk_window_self_clear: assert property (enable_written ##1 idle_cycles |=> !s.change_enable)
		else $error("change enable not cleared after window");
	chk_window_blocks_irq: assert property (enable_written |=> irq_blocked_out && !irq_request_out)
		else $error("request not blocked during change window");
	chk_late_write_ignored: assert property (
		clk_en_in && wr_ctrl && s.phase == IDLE |=> $stable(s.table_select))
		else $error("select changed outside window");
	chk_reset_vector_fuse: assert property (
		clk_en_in && boot_reset_select_fuse_in |=> reset_vector_out == 16'h0000)
		else $error("unprogrammed fuse did not give zero");
	chk_boot_reset_fuse: assert property (
		clk_en_in && !boot_reset_select_fuse_in |=> reset_vector_out == BOOT_START)
		else $error("programmed fuse did not give boot address");
	chk_vector_base_app: assert property (
		$rose(irq_request_out) && !s.table_select |-> irq_vector_out >= 16'h0002
			&& irq_vector_out <= 16'h0030 && irq_vector_out[0] == 1'b0)
		else $error("vector outside application table");
	chk_vector_base_boot: assert property (
		$rose(irq_request_out) && s.table_select |-> irq_vector_out >= BOOT_START + 16'h0002)
		else $error("vector not moved to boot section");
	chk_reserved_silent: assert property (
		$rose(irq_request_out) |-> irq_vector_out != (boot_base + vector_map_pkg::RESERVED_SLOT))
		else $error("reserved slot raised");
	chk_lowest_first: assert property (
		clk_en_in && !blocked && !opening && global_enable_in && !s.request && qualified[0]
		|=> irq_vector_out == table_base)
		else $error("lowest request not chosen");
endmodule
`default_nettype wire

// ---- verif/core_fetch_model.sv ----
// Core fetch side model that takes offered vectors
`timescale 1ns/1ns
`default_nettype none
module core_fetch_model (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Handshake
	input wire logic irq_request_in,
	input wire logic [3:0] ack_wait_in,
	output logic irq_ack_out
);
	logic [3:0] cnt;
	// Takes an offered vector after ack_wait_in idle cycles
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt <= 4'h0;
			irq_ack_out <= 1'b0;
		end else begin
			irq_ack_out <= 1'b0;
			if (irq_request_in && !irq_ack_out) begin
				if (cnt >= ack_wait_in) begin
					irq_ack_out <= 1'b1;
					cnt <= 4'h0;
				end else begin
					cnt <= cnt + 4'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ---- verif/reset_interrupt_vector_map_tb.sv ----
// Self-checking bench for the vector address generator
`timescale 1ns/1ns
`default_nettype none
module reset_interrupt_vector_map_tb;
	localparam logic [15:0] BOOT = 16'h3800;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic fuse = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic [23:0] req = 24'h000000;
	logic done = 1'b0;
	logic gie = 1'b1;
	logic ce = 1'b1;
	logic [3:0] ack_wait = 4'h0;
	logic ack;
	logic irq_req;
	logic blocked;
	logic irq;
	logic [7:0] rdata;
	logic [15:0] vec;
	logic [15:0] rst_vec;
	int n_fail = 0;
	int n_checks = 0;
	logic [15:0] exp_tab [24] = '{16'h0002, 16'h0004, 16'h0006, 16'h0008, 16'h000A,
		16'h000C, 16'h000E, 16'h0010, 16'h0012, 16'h0014, 16'h0016, 16'h0018, 16'h001A,
		16'h001C, 16'h001E, 16'h0020, 16'h0022, 16'h0024, 16'h0026, 16'h0028, 16'h002A,
		16'h002C, 16'h002E, 16'h0030};
	always #25 clk_in = ~clk_in;
	reset_interrupt_vector_map #(.BOOT_START(BOOT)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.clk_en_in(ce), .boot_reset_select_fuse_in(fuse), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_write_in(wr_s), .reg_read_in(rd_s), .reg_rdata_out(rdata),
		.request_in(req), .global_enable_in(gie), .instr_done_in(done), .irq_ack_in(ack),
		.irq_request_out(irq_req), .irq_vector_out(vec), .reset_vector_out(rst_vec),
		.irq_blocked_out(blocked), .irq_out(irq));
	core_fetch_model core (.clk_in(clk_in), .rst_n_in(rst_n_in), .irq_request_in(irq_req),
		.ack_wait_in(ack_wait), .irq_ack_out(ack));
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk_in);
		wr_s <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_in);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk_in);
		rd_s <= 1'b0;
		#1;
		chk("rdata", {8'h00, rdata}, {8'h00, e});
	endtask
	task automatic serve(input logic [15:0] e);
		int k;
		k = 0;
		while (irq_req !== 1'b1 && k < 20) begin
			@(posedge clk_in);
			#1;
			k++;
		end
		chk("irq_vector", vec, e);
		req <= 24'h000000;
		while (irq_req === 1'b1 && k < 40) begin
			@(posedge clk_in);
			#1;
			k++;
		end
	endtask
	task automatic none_for(input int n);
		repeat (n) begin
			@(posedge clk_in);
			#1;
			chk("irq_request", {15'h0000, irq_req}, 16'h0000);
		end
	endtask
	task automatic do_reset(input logic f);
		rst_n_in <= 1'b0;
		fuse <= f;
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		#1;
	endtask
	task automatic tally_and_finish();
		$display("Checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		do_reset(1'b1);
		chk("reset_vector", rst_vec, 16'h0000);
		for (int i = 0; i < 24; i++) begin
			if (i != 21) begin
				req <= 24'h000001 << i;
				serve(exp_tab[i]);
			end
		end
		$display("Test vector table done");
		ack_wait <= 4'h3;
		req <= 24'h000028;
		serve(16'h0008);
		ack_wait <= 4'h0;
		req <= 24'h200000;
		none_for(4);
		req <= 24'h000000;
		$display("Test priority and reserved done");
		gie <= 1'b0;
		req <= 24'h000020;
		none_for(3);
		rd(8'h03, 8'h25);
		gie <= 1'b1;
		serve(16'h000C);
		ce <= 1'b0;
		wr(8'h02, 8'h07);
		ce <= 1'b1;
		rd(8'h02, 8'h00);
		$display("Test global enable and freeze done");
		wr(8'h00, 8'h01);
		chk("blocked", {15'h0000, blocked}, 16'h0001);
		req <= 24'h000001;
		none_for(2);
		req <= 24'h000000;
		repeat (4) @(posedge clk_in);
		#1;
		chk("blocked", {15'h0000, blocked}, 16'h0000);
		wr(8'h00, 8'h02);
		rd(8'h00, 8'h00);
		rd(8'h01, 8'h05);
		chk("irq", {15'h0000, irq}, 16'h0000);
		wr(8'h02, 8'h04);
		chk("irq", {15'h0000, irq}, 16'h0001);
		wr(8'h01, 8'h07);
		chk("irq", {15'h0000, irq}, 16'h0000);
		rd(8'h10, 8'h00);
		$display("Test late select write done");
		wr(8'h00, 8'h01);
		wr(8'h00, 8'h02);
		chk("blocked", {15'h0000, blocked}, 16'h0001);
		@(posedge clk_in);
		done <= 1'b1;
		@(posedge clk_in);
		done <= 1'b0;
		#1;
		chk("blocked", {15'h0000, blocked}, 16'h0000);
		rd(8'h00, 8'h02);
		req <= 24'h000001;
		serve(BOOT + 16'h0002);
		req <= 24'h800000;
		serve(BOOT + 16'h0030);
		$display("Test table move done");
		do_reset(1'b0);
		chk("reset_vector", rst_vec, BOOT);
		req <= 24'h000001;
		serve(16'h0002);
		$display("Test boot reset done");
		tally_and_finish();
	end
	initial begin
		#200000;
		n_fail++;
		$display("Error watchdog expired");
		tally_and_finish();
	end
endmodule
`default_nettype wire
